// ### inc/wdt_pkg.sv
// ============================================================
// watchdog / interval timer shared definitions
package wdt_pkg;

  // register addresses
  localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hFF42;
  localparam logic [15:0] ADDR_MODE_CONTROL = 16'hFF43;

  // reset values
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;

  // clock select fields
  localparam int WD_CLOCK_LSB      = 0;
  localparam int WD_CLOCK_MSB      = 2;
  localparam int CS_ZERO_BIT       = 3;
  localparam int WATCH_PICK_BIT    = 4;
  localparam int BUZZER_LSB        = 5;
  localparam int BUZZER_MSB        = 7;
  localparam logic [7:0] CLOCK_SELECT_WMASK = 8'hF7;

  // mode control fields
  localparam int ACTION_BIT        = 3;
  localparam int MODE_SEL_BIT      = 4;
  localparam int RUN_BIT           = 7;

  // prescaler and count clock exponents
  localparam int PRESC_BITS        = 11;
  localparam logic [3:0] WD_EXP_BASE  = 4'h3;
  localparam logic [3:0] WD_EXP_TOP   = 4'hB;
  localparam logic [3:0] WATCH_EXP    = 4'h7;
  localparam logic [3:0] BUZZER_EXP_BASE = 4'h9;
  localparam logic [2:0] BUZZER_PROHIBITED = 3'h7;

  // exponent of the watchdog count clock divider
  function automatic logic [3:0] wd_clock_exp(input logic [2:0] code);
    if (code == 3'h7) begin
      wd_clock_exp = WD_EXP_TOP;
    end else begin
      wd_clock_exp = WD_EXP_BASE + {1'b0, code};
    end
  endfunction : wd_clock_exp

  // high when the low exp bits of the prescaler are all ones
  function automatic logic tap_tick(input logic [PRESC_BITS-1:0] count,
                                    input logic [3:0] exp);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < PRESC_BITS; i++) begin
      if (i < int'(exp) && !count[i]) begin
        hit = 1'b0;
      end
    end
    tap_tick = hit;
  endfunction : tap_tick

endpackage : wdt_pkg

// ### inc/presc_if.sv
`timescale 1ns/1ps
// ============================================================
// prescaler state shared with the timer core
interface presc_if;
  logic                           fxx_en;
  logic [wdt_pkg::PRESC_BITS-1:0] count;

  modport src (output fxx_en, output count);
  modport dst (input fxx_en, input count);
endinterface : presc_if

// ### core/wdt_prescaler.sv
`timescale 1ns/1ps
// ============================================================
// main clock divider and free-running prescaler
module wdt_prescaler (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic main_clock_undivided_select,
  input  wire logic freeze,
  // prescaler state
  presc_if.src      presc
);

  logic                           half_q;
  logic [wdt_pkg::PRESC_BITS-1:0] count_q;
  logic                           fxx_en;

  // main clock enable: every cycle, or every other cycle
  assign fxx_en = ~freeze & (main_clock_undivided_select | half_q); // R1

  // half-rate phase toggle
  always_ff @(posedge clk) begin
    if (srst) begin
      half_q <= 1'b0;
    end else if (!freeze) begin
      half_q <= ~half_q;
    end
  end

  // prescaler, never cleared by a restart
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (fxx_en) begin
      count_q <= count_q + 1'b1; // R16
    end
  end

  assign presc.fxx_en = fxx_en;
  assign presc.count  = count_q;

endmodule : wdt_prescaler

// ### core/wdt_counter.sv
`timescale 1ns/1ps
// ============================================================
// count clock counter with overflow detect
module wdt_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // control
  input  wire logic             clear,
  input  wire logic             tick,
  // state
  output logic [WIDTH-1:0]      count_q,
  output logic                  overflow
);

  // overflow when a tick meets an all-ones count
  assign overflow = tick & ~clear & (&count_q);

  // clear has priority over counting
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule : wdt_counter

// ### core/watchdog_interval_timer.sv
`timescale 1ns/1ps
// ============================================================
// watchdog_interval_timer
// Contract
// R1: base rate is oscillator, or half when divided
// R2: clock select resets zero, byte writes only
// R3: clock field picks main clock over 2^3..2^9 or 2^11
// R4: detection time is 2^11..2^17 or 2^19
// R5: bit 4 picks watch clock source
// R6: bits 7..5 pick buzzer rate or disable
// R7: software keeps clock field fixed once running
// R8: mode register resets zero, bit or byte writes
// R9: mode and action bits are set-only
// R10: run bit is set-only; only reset stops
// R11: run with mode clear starts interval timing
// R12: mode bit set means watchdog runaway detection
// R13: each run write clears counter and restarts
// R14: software rewrites run before detection time ends
// R15: overflow gives reset or nmi by action bit
// R16: prescaler not cleared, restart up to 0.5% early
// R17: pending flag at mode set forces nmi
// R18: counts in halt, freezes in stop
// R19: software restarts right before entering stop
// R20: counting halts while cpu runs on subclock
// R21: interval overflow raises maskable interval request
// R22: clock select bit 3 reads zero, ignores writes
module watchdog_interval_timer #(
  parameter int COUNT_BITS = 8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register access
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_bit_wr,
  input  wire logic [2:0]  reg_bit_idx,
  input  wire logic        reg_bit_val,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // system state
  input  wire logic        main_clock_undivided_select,
  input  wire logic        halt_mode,
  input  wire logic        stop_mode,
  input  wire logic        cpu_on_subclock,
  input  wire logic        wd_irq_request_flag,
  // requests
  output logic             wdt_reset_req,
  output logic             wdt_nmi_req,
  output logic             interval_irq,
  // shared clock select outputs
  output logic             watch_clock_pick,
  output logic             watch_tick,
  output logic             buzzer_tick,
  // status
  output logic             counting
);

  // ==========================================================
  // declarations
  // state registers
  logic [7:0]            clock_select_q;
  logic                  run_q;
  logic                  mode_sel_q;
  logic                  action_q;
  logic [7:0]            rdata_q;
  logic                  reset_req_q;
  logic                  nmi_req_q;
  logic                  interval_q;
  logic                  watch_tick_q;
  logic                  buzzer_tick_q;

  // decode and datapath nets
  logic                  hit_cs;
  logic                  hit_mode;
  logic                  cs_write;
  logic [7:0]            mode_set;
  logic                  mode_write;
  logic                  run_write;
  logic                  mode_rise;
  logic                  count_en;
  logic                  count_tick;
  logic                  overflow;
  logic [2:0]            wd_code;
  logic [2:0]            buzzer_code;
  logic [3:0]            buzzer_exp;
  logic [COUNT_BITS-1:0] count_value;
  logic [7:0]            rd_mux;
  logic [3:0]            wd_exp;
  logic                  wd_tap;
  logic                  wd_overflow;
  logic                  iv_overflow;
  logic                  buzzer_on;

  // ==========================================================
  // address decode and write strobes
  assign hit_cs   = (reg_addr == wdt_pkg::ADDR_CLOCK_SELECT);
  assign hit_mode = (reg_addr == wdt_pkg::ADDR_MODE_CONTROL);

  // clock select accepts whole-byte writes only
  assign cs_write = reg_wr & hit_cs; // R2

  // bits written to one on the mode register, byte or single bit
  always_comb begin
    mode_set = 8'h00;
    if (reg_wr && hit_mode) begin
      mode_set = reg_wdata;
    end else if (reg_bit_wr && hit_mode && reg_bit_val) begin
      mode_set[reg_bit_idx] = 1'b1; // R8
    end
  end

  assign mode_write = (reg_wr | reg_bit_wr) & hit_mode;
  assign run_write  = mode_write & mode_set[wdt_pkg::RUN_BIT];
  assign mode_rise  = mode_set[wdt_pkg::MODE_SEL_BIT] & ~mode_sel_q;

  // ==========================================================
  // clock select register
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_select_q <= wdt_pkg::CLOCK_SELECT_RESET; // R2
    end else if (cs_write) begin
      clock_select_q <= reg_wdata & wdt_pkg::CLOCK_SELECT_WMASK; // R22
    end
  end

  assign wd_code     = clock_select_q[wdt_pkg::WD_CLOCK_MSB:
                                      wdt_pkg::WD_CLOCK_LSB];
  assign buzzer_code = clock_select_q[wdt_pkg::BUZZER_MSB:
                                      wdt_pkg::BUZZER_LSB];

  // ==========================================================
  // mode control register, set-only bits
  always_ff @(posedge clk) begin
    if (srst) begin
      run_q <= wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::RUN_BIT];
    end else if (run_write) begin
      run_q <= 1'b1; // R10
    end
  end

  // mode select and overflow action only ever go to one
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_sel_q <= wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::MODE_SEL_BIT];
      action_q   <= wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::ACTION_BIT];
    end else if (mode_write) begin
      mode_sel_q <= mode_sel_q | mode_set[wdt_pkg::MODE_SEL_BIT]; // R9
      action_q   <= action_q | mode_set[wdt_pkg::ACTION_BIT]; // R9
    end
  end

  // ==========================================================
  // read port, registered, unmapped reads zero
  // read image of the mode register, unused bits read zero
  function automatic logic [7:0] mode_image(input logic run,
                                            input logic mode_sel,
                                            input logic action);
    logic [7:0] image;
    image = 8'h00;
    image[wdt_pkg::RUN_BIT]      = run;
    image[wdt_pkg::MODE_SEL_BIT] = mode_sel;
    image[wdt_pkg::ACTION_BIT]   = action;
    mode_image = image;
  endfunction : mode_image

  // select the register image for a read
  always_comb begin
    rd_mux = 8'h00;
    if (hit_cs) begin
      rd_mux = clock_select_q; // R22
    end else if (hit_mode) begin
      rd_mux = mode_image(run_q, mode_sel_q, action_q); // R8
    end
  end

  // capture the image on a read strobe, hold it until the next one
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // prescaler and count clock
  presc_if presc ();

  // stop freezes the whole chain, halt does not
  wdt_prescaler u_prescaler (
    .clk                         (clk),
    .srst                        (srst),
    .main_clock_undivided_select (main_clock_undivided_select),
    .freeze                      (stop_mode), // R18
    .presc                       (presc)
  );

  // counting needs run, no stop, and the cpu on the main clock
  assign count_en = run_q & ~stop_mode & ~cpu_on_subclock; // R20

  // exponent of the selected count clock
  assign wd_exp = wdt_pkg::wd_clock_exp(wd_code); // R3

  // prescaler tap for that exponent, once per count clock period
  assign wd_tap = presc.fxx_en & wdt_pkg::tap_tick(presc.count, wd_exp);

  // the counter only advances while counting is allowed
  assign count_tick = count_en & wd_tap;

  // ==========================================================
  // count clock counter: 2^COUNT_BITS ticks to overflow
  wdt_counter #(
    .WIDTH (COUNT_BITS)
  ) u_counter (
    .clk      (clk),
    .srst     (srst),
    .clear    (run_write), // R13
    .tick     (count_tick),
    .count_q  (count_value),
    .overflow (overflow) // R4
  );

  assign counting = count_en;

  // split the overflow by mode; the mode bit never falls back
  assign wd_overflow = overflow & mode_sel_q;  // R12
  assign iv_overflow = overflow & ~mode_sel_q; // R11

  // ==========================================================
  // watchdog reset request
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= wd_overflow & action_q; // R12 R15
    end
  end

  // non-maskable request on watchdog overflow with action clear, or on a forced mode entry
  always_ff @(posedge clk) begin
    if (srst) begin
      nmi_req_q <= 1'b0;
    end else begin
      nmi_req_q <= (wd_overflow & ~action_q) // R15
                 | (mode_rise & wd_irq_request_flag); // R17
    end
  end

  // interval request on every overflow while mode is clear
  always_ff @(posedge clk) begin
    if (srst) begin
      interval_q <= 1'b0;
    end else begin
      interval_q <= iv_overflow; // R11 R21
    end
  end

  assign wdt_reset_req = reset_req_q;
  assign wdt_nmi_req   = nmi_req_q;
  assign interval_irq  = interval_q;

  // ==========================================================
  // watch timer clock from the shared register
  assign watch_clock_pick = clock_select_q[wdt_pkg::WATCH_PICK_BIT];

  // main clock over 2^7 when watch pick is clear
  always_ff @(posedge clk) begin
    if (srst) begin
      watch_tick_q <= 1'b0;
    end else begin
      watch_tick_q <= ~watch_clock_pick & presc.fxx_en
                    & wdt_pkg::tap_tick(presc.count,
                                        wdt_pkg::WATCH_EXP); // R5
    end
  end

  assign watch_tick = watch_tick_q;

  // ==========================================================
  // buzzer rate: top bit enables, low bits pick 2^9..2^11
  assign buzzer_exp = wdt_pkg::BUZZER_EXP_BASE + {2'b00, buzzer_code[1:0]};

  // top bit enables; the prohibited code gives no output
  assign buzzer_on = buzzer_code[2]
                   & (buzzer_code != wdt_pkg::BUZZER_PROHIBITED); // R6

  // one pulse per buzzer period
  always_ff @(posedge clk) begin
    if (srst) begin
      buzzer_tick_q <= 1'b0;
    end else begin
      buzzer_tick_q <= buzzer_on
                     & presc.fxx_en
                     & wdt_pkg::tap_tick(presc.count, buzzer_exp); // R6
    end
  end

  assign buzzer_tick = buzzer_tick_q;

endmodule : watchdog_interval_timer

// ### verification/watchdog_interval_timer_props.sv
`timescale 1ns/1ps
// ============================================================
// port checker for the watchdog / interval timer
module wdt_checker #(
  parameter int COUNT_BITS = 8
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register access
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_bit_wr,
  input wire logic [2:0]  reg_bit_idx,
  input wire logic        reg_bit_val,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // system state and requests
  input wire logic        stop_mode,
  input wire logic        cpu_on_subclock,
  input wire logic        wd_irq_request_flag,
  input wire logic        wdt_reset_req,
  input wire logic        wdt_nmi_req,
  input wire logic        interval_irq,
  input wire logic        counting
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic mode_q;
  logic mode_set;
  // a write that sets the mode select bit
  assign mode_set = reg_addr == wdt_pkg::ADDR_MODE_CONTROL &&
    ((reg_wr && reg_wdata[wdt_pkg::MODE_SEL_BIT]) ||
     (!reg_wr && reg_bit_wr && reg_bit_val &&
      reg_bit_idx == 3'(wdt_pkg::MODE_SEL_BIT)));
  // shadow of the set-only mode bit
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= 1'b0;
    end else if (mode_set) begin
      mode_q <= 1'b1;
    end
  end
  a_reset_quiet: assert property ($past(srst) |->
    !(wdt_reset_req || wdt_nmi_req || interval_irq))
    else $error("request right after reset");
  a_stop_freeze: assert property (stop_mode |-> !counting)
    else $error("counting in stop");
  a_sub_freeze: assert property (cpu_on_subclock |-> !counting)
    else $error("counting on subclock");
  a_run_sticky: assert property (counting ##1
    (!stop_mode && !cpu_on_subclock) |-> counting)
    else $error("counting stopped without reset");
  a_idle_silent: assert property (!counting |=>
    !interval_irq && !wdt_reset_req)
    else $error("overflow while not counting");
  a_interval_mode: assert property (interval_irq |-> !$past(mode_q))
    else $error("interval request in watchdog mode");
  a_watch_mode: assert property (wdt_reset_req |-> $past(mode_q))
    else $error("reset request in interval mode");
  a_mode_nmi: assert property (mode_set && !mode_q &&
    wd_irq_request_flag |=> wdt_nmi_req)
    else $error("no nmi for pending flag");
  a_cs_bit3: assert property (reg_rd &&
    reg_addr == wdt_pkg::ADDR_CLOCK_SELECT |=> !reg_rdata[3])
    else $error("clock select bit 3 not zero");
  a_req_pulse: assert property ((wdt_reset_req || interval_irq) |=>
    !(wdt_reset_req || interval_irq))
    else $error("request longer than one cycle");
  c_interval: cover property (interval_irq);
  c_reset: cover property (wdt_reset_req);
  c_nmi: cover property (wdt_nmi_req);
endmodule : wdt_checker

bind watchdog_interval_timer wdt_checker #(.COUNT_BITS(COUNT_BITS)) chk_u (
  .clk, .srst, .reg_addr, .reg_wr, .reg_bit_wr, .reg_bit_idx,
  .reg_bit_val, .reg_wdata, .reg_rd, .reg_rdata, .stop_mode,
  .cpu_on_subclock, .wd_irq_request_flag, .wdt_reset_req, .wdt_nmi_req,
  .interval_irq, .counting);

// ### verification/watchdog_interval_timer_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module watchdog_interval_timer_bench;
  localparam int CB = 2;
  localparam logic [15:0] CS = wdt_pkg::ADDR_CLOCK_SELECT;
  localparam logic [15:0] MD = wdt_pkg::ADDR_MODE_CONTROL;
  logic        clk = 0, srst = 1, reg_wr = 0, reg_bit_wr = 0, reg_rd = 0;
  logic        reg_bit_val = 0, halt_mode = 0, stop_mode = 0;
  logic        cpu_on_subclock = 0, wd_irq_request_flag = 0;
  logic        main_clock_undivided_select = 1;
  logic [15:0] reg_addr = 0;
  logic [2:0]  reg_bit_idx = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, d;
  logic        wdt_reset_req, wdt_nmi_req, interval_irq;
  logic        watch_clock_pick, counting, rd_q = 0;
  logic        watch_tick, buzzer_tick;
  int          nw = 0, nb = 0;
  logic [31:0] rq[$], pq[$], e, g;
  int          fail_count = 0, n_compared = 0;
  int unsigned cyc = 0, last = 0;

  watchdog_interval_timer #(.COUNT_BITS(CB)) dut_u (
    .clk, .srst, .reg_addr, .reg_wr, .reg_bit_wr, .reg_bit_idx,
    .reg_bit_val, .reg_wdata, .reg_rd, .reg_rdata,
    .main_clock_undivided_select, .halt_mode, .stop_mode,
    .cpu_on_subclock, .wd_irq_request_flag, .wdt_reset_req, .wdt_nmi_req,
    .interval_irq, .watch_clock_pick, .watch_tick, .buzzer_tick,
    .counting);

  // ============================================================
  // clock, cycle count and read tracking
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    rd_q <= reg_rd;
  end
  // compare reads and request pulses with the oldest note
  always @(negedge clk) begin
    nw += watch_tick;
    nb += buzzer_tick;
    if (rd_q) begin
      e = rq.size() ? rq.pop_front() : 32'hFFFFFFFF;
      `CHK({24'h0, reg_rdata}, e)
    end
    if (wdt_reset_req | wdt_nmi_req | interval_irq) begin
      e = pq.size() ? pq.pop_front() : 32'hFFFFFFFF;
      g = {24'(cyc - last), 5'h0, wdt_reset_req, wdt_nmi_req, interval_irq};
      last = cyc;
      `CHK(e[31:8] == 0 ? {24'h0, g[7:0]} : g, e)
    end
  end

  // ============================================================
  // bus tasks, all driven at the falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask : wr
  task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic v);
    @(negedge clk);
    reg_addr = a;
    reg_bit_idx = i;
    reg_bit_val = v;
    reg_bit_wr = 1;
    @(negedge clk);
    reg_bit_wr = 0;
  endtask : bw
  task automatic rd(input logic [15:0] a, input logic [7:0] v);
    rq.push_back({24'h0, v});
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
  endtask : rd
  // note an expected pulse; a gap of zero is not checked
  task automatic pe(input int gap, input logic [7:0] f);
    pq.push_back({gap[23:0], f});
  endtask : pe
  task automatic drain;
    for (int i = 0; i < 40000 && pq.size() != 0; i++) @(negedge clk);
  endtask : drain
  task automatic rst;
    @(negedge clk);
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
  endtask : rst
  // overflow period in clk cycles for a code and clock halving
  function automatic int per(input int c, input logic m);
    per = (1 << ((c == 7 ? 11 : c + 3) + CB)) << !m;
  endfunction : per
  // count watch and buzzer pulses over one 2^11 cycle window
  task automatic tk(input logic [7:0] v, input int w, input int b);
    wr(CS, v);
    @(posedge clk);
    nw = 0;
    nb = 0;
    repeat (2048) @(posedge clk);
    `CHK(nw, w)
    `CHK(nb, b)
  endtask : tk
  task automatic finish_test;
    // let the last read and pulse compares land first
    repeat (2) @(negedge clk);
    fail_count += pq.size() + rq.size();
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ============================================================
  // test sequence
  initial begin
    void'($urandom(92335));
    rst();
    rd(CS, 8'h00);
    rd(MD, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(CS, d);
      `CHK(watch_clock_pick, d[4])
      rd(CS, d & 8'hF7);
    end
    bw(CS, 3'h0, ~d[0]);
    rd(CS, d & 8'hF7);
    tk(8'h80, 16, 4);
    tk(8'hD0, 0, 1);
    tk(8'hF0, 0, 0);
    tk(8'h60, 16, 0);
    wr(16'hFF44, 8'($urandom));
    rd(16'hFF44, 8'h00);
    bw(MD, 3'h3, 1);
    bw(MD, 3'h3, 0);
    rd(MD, 8'h08);
    for (int c = 0; c < 8; c++) begin
      rst();
      main_clock_undivided_select = c[0];
      wr(CS, 8'(c));
      pe(0, 8'h01);
      pe(per(c, c[0]), 8'h01);
      wr(MD, 8'h80);
      drain();
      rd(MD, 8'h80);
    end
    rst();
    halt_mode = 1;
    wr(CS, 8'h00);
    wr(MD, 8'h90);
    repeat (6) begin
      repeat (20) @(negedge clk);
      bw(MD, 3'h7, 1);
    end
    pe(0, 8'h02);
    pe(32, 8'h02);
    drain();
    bw(MD, 3'h7, 1);
    stop_mode = 1;
    repeat (100) @(negedge clk);
    stop_mode = 0;
    cpu_on_subclock = 1;
    repeat (100) @(negedge clk);
    cpu_on_subclock = 0;
    pe(0, 8'h02);
    drain();
    rst();
    wr(CS, 8'h00);
    bw(MD, 3'h3, 1);
    wd_irq_request_flag = 1;
    pe(0, 8'h02);
    bw(MD, 3'h4, 1);
    wd_irq_request_flag = 0;
    bw(MD, 3'h4, 0);
    pe(0, 8'h04);
    pe(32, 8'h04);
    bw(MD, 3'h7, 1);
    drain();
    rd(MD, 8'h98);
    finish_test();
  end
  // hang guard
  initial begin
    #700000;
    fail_count++;
    finish_test();
  end
endmodule : watchdog_interval_timer_bench
